// File: core/pdd_divider.sv
`timescale 1ns/10ps
module pdd_divider #(
  parameter int LOCK_WIN = pdd_pkg::LOCK_WIN_CYC
) (
  input  wire  logic        clock,
  input  wire  logic        rstn,
  input  wire  logic        vco_in,
  input  wire  logic        ref_in,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               div_out,
  output logic               pump_up,
  output logic               pump_down,
  output logic               lock
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The lone-pulse counter is 16 bits, so the window must fit in it
  if (LOCK_WIN < 1 || LOCK_WIN > 65535) begin : g_bad_lock_win
    $error("LOCK_WIN must lie in 1..65535");
  end

  // Preset wiring and the chain read-back assume six decade stages
  if (pdd_pkg::STAGES != 6) begin : g_bad_stages
    $error("STAGES must be 6");
  end

  // The two moduli must differ by one count or the ratio drifts
  if (pdd_pkg::PSC_DIV11 != pdd_pkg::PSC_DIV10 + 4'h1) begin : g_bad_psc
    $error("prescaler end counts must differ by one");
  end

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  logic vco_prev_q;
  logic ref_prev_q;
  logic vco_edge;
  logic ref_edge;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vco_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      vco_prev_q <= vco_in;
      ref_prev_q <= ref_in;
    end
  end

  // One count per sampled rise; each VCO level must last a full clock
  assign vco_edge = vco_in & ~vco_prev_q;
  assign ref_edge = ref_in & ~ref_prev_q;

  // ----------------------------------------------------------------
  // Frequency select register
  // ----------------------------------------------------------------
  logic [15:0] select_q;
  logic        wr_en;

  // pready is high in every access phase, so it is left out of the strobe
  assign wr_en = psel & penable & pwrite;

  // Digits are taken as written; a non-BCD nibble wraps to zero on its next count, with no carry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      select_q <= pdd_pkg::SELECT_RST;
    end else if (wr_en && paddr == pdd_pkg::ADDR_SELECT) begin
      select_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Dual-modulus prescaler
  // ----------------------------------------------------------------
  logic       modulus_q;
  logic       reload_q;
  logic [3:0] psc_q;
  logic [3:0] psc_last;
  logic       tick;

  // Reload holds the prescaler at ten so both reload phases are 10 counts
  assign psc_last = (modulus_q | reload_q) ? pdd_pkg::PSC_DIV10
                                            : pdd_pkg::PSC_DIV11;
  // Tick marks the last input count of each prescaler cycle
  assign tick     = vco_edge & (psc_q == psc_last);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      psc_q <= 4'h0;
    end else if (vco_edge) begin
      psc_q <= (psc_q == psc_last) ? 4'h0 : psc_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Decade chain
  // ----------------------------------------------------------------
  logic [3:0] digit_q [pdd_pkg::STAGES];
  logic [3:0] preset  [pdd_pkg::STAGES];
  logic       advance [pdd_pkg::STAGES];
  logic       units_term;
  logic       reload_term;

  assign preset[0] = select_q[3:0];
  assign preset[1] = select_q[7:4];
  assign preset[2] = select_q[11:8];
  assign preset[3] = select_q[15:12];
  assign preset[4] = pdd_pkg::FIFTH_LOAD;
  assign preset[5] = pdd_pkg::SIXTH_LOAD;

  // Units count only at divide-by-eleven; tens count on every tick outside reload
  assign advance[0] = tick & ~reload_q & ~modulus_q;
  assign advance[1] = tick & ~reload_q;

  // Carry ripples only through stages that already hold nine
  genvar k;
  generate
    for (k = 2; k < pdd_pkg::STAGES; k++) begin : g_carry
      assign advance[k] = advance[k-1] &
                          (digit_q[k-1] == pdd_pkg::DIGIT_MAX);
    end
    for (k = 0; k < pdd_pkg::STAGES; k++) begin : g_stage
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          digit_q[k] <= 4'h0;
        end else if (reload_q) begin
          digit_q[k] <= preset[k];
        end else if (advance[k]) begin
          digit_q[k] <= (digit_q[k] >= pdd_pkg::DIGIT_MAX) ? 4'h0
                        : digit_q[k] + 4'h1;
        end
      end
    end
  endgenerate

  // Units alone at nine arms the modulus flop; with a zero setting the
  // tens stage is at nine in the same tick
  assign units_term  = ~modulus_q &
                       (digit_q[0] == pdd_pkg::DIGIT_MAX);
  assign reload_term = (digit_q[1] == pdd_pkg::TENS_TERM) &
                       (digit_q[2] == pdd_pkg::DIGIT_MAX) &
                       (digit_q[3] == pdd_pkg::DIGIT_MAX) &
                       (digit_q[4] == pdd_pkg::DIGIT_MAX) &
                       (digit_q[5] == pdd_pkg::DIGIT_MAX);

  // ----------------------------------------------------------------
  // Modulus and reload flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modulus_q <= 1'b0;
    end else if (reload_q) begin
      // Reload acts as a held clear and wins over the arming tick
      modulus_q <= 1'b0;
    end else if (tick && units_term) begin
      modulus_q <= 1'b1;
    end
  end

  // Ratio per cycle comes to 800000 minus the four-digit setting
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reload_q <= 1'b0;
    end else if (tick) begin
      reload_q <= reload_q ? 1'b0 : reload_term;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_out <= 1'b0;
    end else begin
      div_out <= reload_q;
    end
  end

  // ----------------------------------------------------------------
  // Phase/frequency detector
  // ----------------------------------------------------------------
  logic div_edge;
  logic both_set;

  // Divider edge is the tick that sets the reload flop
  assign div_edge = tick & ~reload_q & reload_term;
  assign both_set = pump_up & pump_down;

  // A new edge in the clearing cycle wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pump_up <= 1'b0;
    end else begin
      pump_up <= div_edge | (pump_up & ~both_set);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pump_down <= 1'b0;
    end else begin
      pump_down <= ref_edge | (pump_down & ~both_set);
    end
  end

  // ----------------------------------------------------------------
  // Lock detector
  // ----------------------------------------------------------------
  logic [15:0] single_cnt_q;
  logic        over_win;
  logic        viol_q;

  // Counter saturates at the window so a stuck flop never wraps to zero
  assign over_win = (single_cnt_q >= 16'(LOCK_WIN));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      single_cnt_q <= 16'h0000;
    end else if (!(pump_up ^ pump_down)) begin
      single_cnt_q <= 16'h0000;
    end else if (!over_win) begin
      single_cnt_q <= single_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      viol_q <= 1'b0;
    end else begin
      viol_q <= over_win | (viol_q & ~ref_edge);
    end
  end

  // Judged once per reference period; starts unlocked
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock <= 1'b0;
    end else if (ref_edge) begin
      lock <= ~viol_q & ~over_win;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  pdd_pkg::pdd_status_s status;
  logic                 setup;

  assign setup = psel & ~penable;

  always_comb begin
    status           = '0;
    status.locked    = lock;
    status.pump_up   = pump_up;
    status.pump_down = pump_down;
    status.modulus   = modulus_q;
    status.reload    = reload_q;
  end

  // Data is prepared in the setup cycle so every access ends in one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (paddr)
        pdd_pkg::ADDR_SELECT: begin
          prdata <= {16'h0000, select_q};
        end
        pdd_pkg::ADDR_STATUS: begin
          prdata <= {16'h0000, status};
        end
        pdd_pkg::ADDR_CHAIN: begin
          prdata <= {8'h00, digit_q[5], digit_q[4], digit_q[3],
                     digit_q[2], digit_q[1], digit_q[0]};
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // No wait states: low only in reset, high from the first edge on
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

endmodule : pdd_divider

// File: core/pdd_pkg.sv
// Function
// - Preset loads digits, zero, then two
// - Modulus clear: divide by eleven, low stages
// - Units at nine arms modulus, next tick sets
// - Modulus set: units stop, divide by ten
// - Tens seven, upper nines arm reload
// - Reload sets, clears modulus, presets chain
// - Reload clears next tick, one pulse cycle
// - Ratio is base minus selected setting
// - Divider leads: up first, then both clear
// - Divider lags: down first, then both clear
// - Lock indication derived from detector state
package pdd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_SELECT = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_CHAIN  = 8'h08;
  localparam logic [15:0] SELECT_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Divider constants
  // ----------------------------------------------------------------
  localparam int          STAGES      = 6;
  localparam logic [3:0]  FIFTH_LOAD  = 4'h0;
  localparam logic [3:0]  SIXTH_LOAD  = 4'h2;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  localparam logic [3:0]  TENS_TERM   = 4'h7;
  localparam logic [3:0]  PSC_DIV11   = 4'hA;
  localparam logic [3:0]  PSC_DIV10   = 4'h9;

  // ----------------------------------------------------------------
  // Lock window: shortest single-flop pulse that already counts as unlocked
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LOCK_WIN_PS   = 64000;
  localparam int LOCK_WIN_CYC  = (LOCK_WIN_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 LOCK_WIN_PS / CLK_PERIOD_PS;

  typedef struct packed {
    logic [10:0] spare;
    logic        reload;
    logic        modulus;
    logic        pump_down;
    logic        pump_up;
    logic        locked;
  } pdd_status_s;

endpackage : pdd_pkg

// File: dv/pdd_divider_properties.sv
`timescale 1ns/10ps
module pdd_chk #(
  parameter int LOCK_WIN = 16
) (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       ref_in,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       div_out,
  input wire logic       pump_up,
  input wire logic       pump_down,
  input wire logic       lock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [15:0] one_q;
  logic [1:0]  age_q;
  logic        acc;
  logic        map;
  assign acc = psel && penable;
  assign map = paddr inside {pdd_pkg::ADDR_SELECT, pdd_pkg::ADDR_STATUS,
                             pdd_pkg::ADDR_CHAIN};
  // Run of a lone pump pulse; saturates so a stuck flop never wraps
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) one_q <= '0;
    else if (!(pump_up ^ pump_down)) one_q <= '0;
    else if (one_q != 16'hFFFF) one_q <= one_q + 16'h1;
  end
  // Clocks since the last reference rise, parked at 3 when stale
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) age_q <= 2'h3;
    else if ($rose(ref_in)) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  a_ready_access: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (acc && !map |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (acc && map |-> !pslverr)
    else $error("error on mapped address");
  a_pump_overlap: assert property (
    pump_up && pump_down |=> !(pump_up && pump_down))
    else $error("pump overlap longer than one clock");
  a_down_on_ref: assert property ($rose(ref_in) |-> ##[1:3] pump_down)
    else $error("reference rise did not set down flop");
  a_up_then_div: assert property ($rose(pump_up) |=> div_out)
    else $error("up flop set without reload pulse");
  a_reload_width: assert property ($rose(div_out) |-> div_out[*8])
    else $error("reload pulse too short");
  a_lock_at_ref: assert property ($changed(lock) |-> age_q != 2'h3)
    else $error("lock changed away from reference edge");
  a_lock_drop: assert property (
    $rose(ref_in) && one_q > LOCK_WIN + 4 |-> ##[1:3] !lock)
    else $error("lock kept after long pump pulse");
endmodule : pdd_chk

bind pdd_divider pdd_chk #(.LOCK_WIN(LOCK_WIN)) u_pdd_chk (
  .clock, .rstn, .ref_in, .psel, .penable, .paddr, .pready, .pslverr,
  .div_out, .pump_up, .pump_down, .lock);

// File: dv/pdd_osc_model.sv
`timescale 1ns/10ps
module pdd_osc_model #(
  parameter int REF_HALF = 50
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic vco_run,
  input  wire logic ref_run,
  output logic      vco_in,
  output logic      ref_in
);
  int ref_cnt;
  // Toggle every clock: one count per two clocks, the fastest sampled rate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) vco_in <= 1'b0;
    else if (vco_run) vco_in <= ~vco_in;
  end
  // Square reference train, frozen at its current level while disabled
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_cnt <= 0;
      ref_in  <= 1'b0;
    end else if (ref_run) begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      if (ref_cnt == REF_HALF - 1) ref_in <= ~ref_in;
    end
  end
endmodule : pdd_osc_model

// File: dv/pdd_divider_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pdd_divider_tb_top;
  logic        clock;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        vco_run = 1'b0;
  logic        ref_run = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, div_out, pump_up, pump_down, lock;
  logic        vco_in, ref_in;
  int          fails   = 0;
  int          n_tests = 0;

  pdd_divider #(.LOCK_WIN(4)) u_pdd_divider (
    .clock, .rstn, .vco_in, .ref_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .div_out, .pump_up,
    .pump_down, .lock);
  pdd_osc_model u_pdd_osc_model (
    .clock, .rstn, .vco_run, .ref_run, .vco_in, .ref_in);

  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Result is {pslverr, prdata} as taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n >= 50) begin
      fails++;
      stop_test();
    end
  endtask : apb

  task automatic t_regs();
    logic [32:0] r;
    apb(1'b0, pdd_pkg::ADDR_SELECT, 32'h0, r);
    `CHK(r, 33'h0)
    apb(1'b1, pdd_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r);
    apb(1'b0, pdd_pkg::ADDR_STATUS, 32'h0, r);
    `CHK(r, 33'h0)
    apb(1'b0, 8'h0C, 32'h0, r);
    `CHK(r, 33'h1_0000_0000)
    apb(1'b1, pdd_pkg::ADDR_SELECT, 32'h0000_9370, r);
    apb(1'b0, pdd_pkg::ADDR_SELECT, 32'h0, r);
    `CHK(r, 33'h0_0000_9370)
  endtask : t_regs

  // Chain runs from zero until the first reload, so early counts are known
  task automatic t_count();
    int          cnt [4] = '{11, 88, 11, 10};
    logic [32:0] exp [4] = '{33'h11, 33'h99, 33'h100, 33'h110};
    logic [32:0] r;
    for (int i = 0; i < 4; i++) begin
      vco_run <= 1'b1;
      repeat (2 * cnt[i]) @(posedge clock);
      vco_run <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1'b0, pdd_pkg::ADDR_CHAIN, 32'h0, r);
      `CHK(r, exp[i])
      apb(1'b0, pdd_pkg::ADDR_STATUS, 32'h0, r);
      `CHK(r[3], i > 1)
      `CHK({div_out, pump_up, r[4]}, 3'b000)
    end
  endtask : t_count

  task automatic wait_ref();
    int n;
    n = 0;
    while (ref_in !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    while (ref_in !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      fails++;
      stop_test();
    end
  endtask : wait_ref

  // Reference only, divider silent: down flop stays set and lock drops
  task automatic t_pfd();
    logic [32:0] r;
    ref_run <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_ref();
      repeat (4) @(posedge clock);
      `CHK({lock, pump_up, pump_down}, {i == 0, 2'b01})
    end
    apb(1'b0, pdd_pkg::ADDR_STATUS, 32'h0, r);
    `CHK(r, 33'hC)
    ref_run <= 1'b0;
  endtask : t_pfd

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_count();
    t_pfd();
    stop_test();
  end
endmodule : pdd_divider_tb_top
